// file: core/adc_fmt_pkg.sv
// Constants for the converter power-state and output formatter block.
// Assumes a single system clock that oversamples the separate sampling clock.
// Functional notes
// - Chip power down, channel standby, output tri-state; chosen by field or pins.
// - Codes 1001, 1010, 1011 tri-state B, A, both; recovery about 100 ns.
// - Code 1100 or pins high-low-low powers down; data valid 20 us later.
// - Codes 1101/1110 or pins HLH/HHL put channel B/A in standby; 1 us wake.
// - Code 1111 or pins all high multiplex both channels onto channel A bus.
// - Code 0000 or pins low give normal; pins cannot select tri-state.
// - Chip power down turns everything off and floats all data outputs.
// - Sampling clock below 1 MSPS forces a low-power state automatically.
// - Each channel outputs an 11-bit word with a data-synchronous clock.
// - Output style DDR or CMOS, chosen by register bit or format pin.
// - DDR mode carries two sample bits per pair each clock period; here pin k carries only bit k, zero in the other phase.
// - DDR even bits launch at clock fall, odd bits at clock rise.
// - CMOS drives each bit on own pin once per cycle; rising-edge capture.
// - Samples encoded two's complement or offset binary by bit or pin.
// - Positive overdrive clamps to 7FF offset binary, 3FF two's complement.
// - Negative overdrive clamps to 000 offset binary, 400 two's complement.
// - Configuration writes carry an 8-bit address and 8-bit data.
package adc_fmt_pkg;
  localparam int SAMPLE_W = 11;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  // Register byte addresses
  localparam logic [7:0] ADDR_POWER = 8'h00;
  localparam logic [7:0] ADDR_OUTPUT = 8'h01;
  localparam logic [7:0] ADDR_STATUS = 8'h02;
  // Field positions
  localparam int POWER_CODE_LSB = 0;
  localparam int OUT_STYLE_BIT = 0;
  localparam int OUT_FORMAT_BIT = 1;
  localparam int OUT_PINSEL_BIT = 2;
  localparam logic [3:0] POWER_RESET = 4'h0;
  localparam logic [7:0] OUTPUT_RESET = 8'h00;
  // Power-state codes
  localparam logic [3:0] CODE_NORMAL = 4'h0;
  localparam logic [3:0] CODE_TRI_B = 4'h9;
  localparam logic [3:0] CODE_TRI_A = 4'hA;
  localparam logic [3:0] CODE_TRI_AB = 4'hB;
  localparam logic [3:0] CODE_GLOBAL = 4'hC;
  localparam logic [3:0] CODE_STBY_B = 4'hD;
  localparam logic [3:0] CODE_STBY_A = 4'hE;
  localparam logic [3:0] CODE_MUX = 4'hF;
  // Clamp codes
  localparam logic [10:0] POS_CLAMP_OB = 11'h7FF;
  localparam logic [10:0] POS_CLAMP_TC = 11'h3FF;
  localparam logic [10:0] NEG_CLAMP_OB = 11'h000;
  localparam logic [10:0] NEG_CLAMP_TC = 11'h400;
  localparam logic [10:0] SIGN_FLIP = 11'h400;
  // Timing
  localparam int CLK_NS = 50;
  localparam int TRI_WAKE_NS = 100;
  localparam int STBY_WAKE_US = 1;
  localparam int GLOBAL_WAKE_US = 20;
  localparam int TRI_WAKE_CYC = (TRI_WAKE_NS + CLK_NS - 1) / CLK_NS;
  localparam int STBY_WAKE_CYC = (STBY_WAKE_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int GLOBAL_WAKE_CYC = (GLOBAL_WAKE_US * 1000 + CLK_NS - 1) / CLK_NS;
  // Slowest sampling rate before low power: 1 MSPS means 1000 ns per sample
  localparam int MIN_RATE_PERIOD_NS = 1000;
  localparam int SLOW_LIMIT_CYC = MIN_RATE_PERIOD_NS / CLK_NS;
  localparam int WAKE_CNT_W = 12;
  localparam int EDGE_CNT_W = 8;
endpackage

// file: core/adc_sample_encoder.sv
// Encodes one channel's raw offset-binary sample and applies overdrive clamps.
// Assumes raw sample and overdrive flags are synchronous to the system clock.
`timescale 1ns/1ps
`default_nettype none
module adc_sample_encoder #(
  parameter int WIDTH = 11
) (
  input wire logic [WIDTH-1:0] i_raw,
  input wire logic i_over_pos,
  input wire logic i_over_neg,
  input wire logic i_twos,
  output logic [WIDTH-1:0] o_code
);
  always_comb begin
    if (i_over_pos) begin
      o_code = i_twos ? adc_fmt_pkg::POS_CLAMP_TC : adc_fmt_pkg::POS_CLAMP_OB;
    end else if (i_over_neg) begin
      o_code = i_twos ? adc_fmt_pkg::NEG_CLAMP_TC : adc_fmt_pkg::NEG_CLAMP_OB;
    end else if (i_twos) begin
      o_code = i_raw ^ adc_fmt_pkg::SIGN_FLIP;
    end else begin
      o_code = i_raw;
    end
  end
endmodule
`default_nettype wire

// file: core/adc_power_and_output_formatter.sv
// Power-state control and output formatting for a dual-channel converter.
// Assumes raw samples arrive on I_CLK; sampling clock and pins are asynchronous.
//
// The strobed register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module adc_power_and_output_formatter #(
  parameter int WIDTH = 11,
  parameter int GLOBAL_WAKE = adc_fmt_pkg::GLOBAL_WAKE_CYC
) (
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic [7:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [7:0] O_RDATA,
  input wire logic I_POWER_PIN_FIRST,
  input wire logic I_POWER_PIN_SECOND,
  input wire logic I_POWER_PIN_THIRD,
  input wire logic I_FORMAT_SELECT_PIN,
  input wire logic I_SAMPLE_CLK,
  input wire logic [WIDTH-1:0] I_RAW_A,
  input wire logic [WIDTH-1:0] I_RAW_B,
  input wire logic [1:0] I_OVER_POS,
  input wire logic [1:0] I_OVER_NEG,
  output logic [WIDTH-1:0] O_DATA_A,
  output logic [WIDTH-1:0] O_DATA_B,
  output logic [WIDTH-1:0] O_DATA_A_OE,
  output logic [WIDTH-1:0] O_DATA_B_OE,
  output logic O_DDR_OUTPUT_CLOCK,
  output logic O_CMOS_OUTPUT_CLOCK,
  output logic O_CONV_A_ON,
  output logic O_CONV_B_ON,
  output logic O_REF_ON,
  output logic O_LOW_POWER,
  output logic O_DATA_VALID
);
  typedef enum logic [3:0] {
    ST_RUN = 4'h1,
    ST_WAKE = 4'h2,
    ST_GLOBAL = 4'h4,
    ST_SLOW = 4'h8
  } pwr_type;

  // Synchronisers for pins and sampling clock
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic sclk_prev;
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      sync1 <= 5'h00;
      sync2 <= 5'h00;
      sclk_prev <= 1'b0;
    end else begin
      sync1 <= {I_SAMPLE_CLK, I_FORMAT_SELECT_PIN, I_POWER_PIN_THIRD, I_POWER_PIN_SECOND,
                I_POWER_PIN_FIRST};
      sync2 <= sync1;
      sclk_prev <= sync2[4];
    end
  end
  logic sclk_rise;
  logic sclk_fall;
  assign sclk_rise = sync2[4] & ~sclk_prev;
  assign sclk_fall = ~sync2[4] & sclk_prev;

  // Register file: 8-bit address, 8-bit data
  logic [3:0] power_code;
  logic [7:0] out_ctrl;
  logic [3:0] next_power_code;
  logic [7:0] next_out_ctrl;
  logic [7:0] next_rdata;
  pwr_type state;
  logic [3:0] eff_code;
  always_comb begin
    next_power_code = power_code;
    next_out_ctrl = out_ctrl;
    next_rdata = 8'h00;
    if (I_WR) begin
      unique case (I_ADDR)
        adc_fmt_pkg::ADDR_POWER: next_power_code = I_WDATA[3:0];
        adc_fmt_pkg::ADDR_OUTPUT: next_out_ctrl = {5'h00, I_WDATA[2:0]};
        default: ;
      endcase
    end
    if (I_RD) begin
      unique case (I_ADDR)
        adc_fmt_pkg::ADDR_POWER: next_rdata = {4'h0, power_code};
        adc_fmt_pkg::ADDR_OUTPUT: next_rdata = out_ctrl;
        adc_fmt_pkg::ADDR_STATUS: next_rdata = {state, eff_code};
        default: next_rdata = 8'h00;
      endcase
    end
  end
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      power_code <= adc_fmt_pkg::POWER_RESET;
      out_ctrl <= adc_fmt_pkg::OUTPUT_RESET;
    end else begin
      power_code <= next_power_code;
      out_ctrl <= next_out_ctrl;
    end
  end

  // Pin mode selected by register bit; pins win then
  logic pin_mode;
  logic style_cmos;
  logic twos;
  assign pin_mode = out_ctrl[adc_fmt_pkg::OUT_PINSEL_BIT];
  assign style_cmos = pin_mode ? sync2[3] : out_ctrl[adc_fmt_pkg::OUT_STYLE_BIT];
  assign twos = pin_mode ? sync2[3] : out_ctrl[adc_fmt_pkg::OUT_FORMAT_BIT];

  always_comb begin
    eff_code = power_code;
    if (pin_mode) begin
      unique case (sync2[2:0])
        3'b001: eff_code = adc_fmt_pkg::CODE_GLOBAL;
        3'b101: eff_code = adc_fmt_pkg::CODE_STBY_B;
        3'b011: eff_code = adc_fmt_pkg::CODE_STBY_A;
        3'b111: eff_code = adc_fmt_pkg::CODE_MUX;
        default: eff_code = adc_fmt_pkg::CODE_NORMAL;
      endcase
    end
  end

  // Decoded mode flags; codes below 1001 fall through to normal
  logic tri_a;
  logic tri_b;
  logic stby_a;
  logic stby_b;
  logic mux_mode;
  logic global_pd;
  always_comb begin
    tri_a = 1'b0;
    tri_b = 1'b0;
    stby_a = 1'b0;
    stby_b = 1'b0;
    mux_mode = 1'b0;
    global_pd = 1'b0;
    unique case (eff_code)
      adc_fmt_pkg::CODE_TRI_B: tri_b = 1'b1;
      adc_fmt_pkg::CODE_TRI_A: tri_a = 1'b1;
      adc_fmt_pkg::CODE_TRI_AB: begin
        tri_a = 1'b1;
        tri_b = 1'b1;
      end
      adc_fmt_pkg::CODE_GLOBAL: global_pd = 1'b1;
      adc_fmt_pkg::CODE_STBY_B: stby_b = 1'b1;
      adc_fmt_pkg::CODE_STBY_A: stby_a = 1'b1;
      adc_fmt_pkg::CODE_MUX: mux_mode = 1'b1;
      default: ;
    endcase
  end

  // Sample clock watchdog: no edge within the limit means too slow
  logic [7:0] gap;
  logic [7:0] next_gap;
  logic slow;
  assign slow = gap >= 8'(adc_fmt_pkg::SLOW_LIMIT_CYC);
  always_comb begin
    next_gap = gap;
    if (sclk_rise) begin
      next_gap = 8'h00;
    end else if (!slow) begin
      next_gap = gap + 8'h01;
    end
  end

  // Power sequencer with wake-up timer
  pwr_type next_state;
  logic [11:0] wake;
  logic [11:0] next_wake;
  logic stby_a_q;
  logic stby_b_q;
  logic tri_any_q;
  logic [1:0] tri_q;
  logic stby_rise;
  logic tri_fall;
  assign stby_rise = (stby_a_q & ~stby_a) | (stby_b_q & ~stby_b);
  assign tri_fall = tri_any_q & ~(tri_a | tri_b);
  always_comb begin
    next_state = state;
    next_wake = wake;
    unique case (state)
      ST_RUN: begin
        if (slow) begin
          next_state = ST_SLOW;
        end else if (global_pd) begin
          next_state = ST_GLOBAL;
        end else if (stby_rise) begin
          next_state = ST_WAKE;
          next_wake = 12'(adc_fmt_pkg::STBY_WAKE_CYC);
        end else if (tri_fall) begin
          next_state = ST_WAKE;
          next_wake = 12'(adc_fmt_pkg::TRI_WAKE_CYC);
        end
      end
      ST_WAKE: begin
        if (slow) begin
          next_state = ST_SLOW;
        end else if (global_pd) begin
          next_state = ST_GLOBAL;
        end else if (wake <= 12'h001) begin
          next_state = ST_RUN;
          next_wake = 12'h000;
        end else begin
          next_wake = wake - 12'h001;
        end
      end
      ST_GLOBAL, ST_SLOW: begin
        if (!global_pd && !slow) begin
          next_state = ST_WAKE;
          next_wake = 12'(GLOBAL_WAKE);
        end
      end
    endcase
  end
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state <= ST_RUN;
      wake <= 12'h000;
      gap <= 8'h00;
      stby_a_q <= 1'b0;
      stby_b_q <= 1'b0;
      tri_any_q <= 1'b0;
      tri_q <= 2'b00;
    end else begin
      state <= next_state;
      wake <= next_wake;
      gap <= next_gap;
      stby_a_q <= stby_a;
      stby_b_q <= stby_b;
      tri_any_q <= tri_a | tri_b;
      tri_q <= {tri_b, tri_a};
    end
  end

  // Encoding of each channel
  logic [WIDTH-1:0] code_a;
  logic [WIDTH-1:0] code_b;
  adc_sample_encoder #(.WIDTH(WIDTH)) enc_a (
    .i_raw(I_RAW_A),
    .i_over_pos(I_OVER_POS[0]),
    .i_over_neg(I_OVER_NEG[0]),
    .i_twos(twos),
    .o_code(code_a)
  );
  adc_sample_encoder #(.WIDTH(WIDTH)) enc_b (
    .i_raw(I_RAW_B),
    .i_over_pos(I_OVER_POS[1]),
    .i_over_neg(I_OVER_NEG[1]),
    .i_twos(twos),
    .o_code(code_b)
  );

  // Output path: words latched on sampling clock rise
  logic [WIDTH-1:0] word_a;
  logic [WIDTH-1:0] word_b;
  logic mux_sel;
  logic [WIDTH-1:0] next_word_a;
  logic [WIDTH-1:0] next_word_b;
  logic next_mux_sel;
  always_comb begin
    next_word_a = word_a;
    next_word_b = word_b;
    next_mux_sel = mux_sel;
    if (sclk_rise) begin
      next_word_a = code_a;
      next_word_b = code_b;
      next_mux_sel = mux_mode ? ~mux_sel : 1'b0;
    end
  end

  logic off;
  logic oe_a;
  logic oe_b;
  assign off = (state == ST_GLOBAL) || (state == ST_SLOW);
  assign oe_a = !off && !tri_q[0];
  assign oe_b = !off && !tri_q[1] && !mux_mode;

  logic [WIDTH-1:0] next_data_a;
  logic [WIDTH-1:0] next_data_b;
  logic [WIDTH-1:0] next_oe_a;
  logic [WIDTH-1:0] next_oe_b;
  logic next_ddr_clk;
  logic next_cmos_clk;
  logic [WIDTH-1:0] src_a;
  always_comb begin
    src_a = (mux_mode && mux_sel) ? word_b : word_a;
    next_data_a = O_DATA_A;
    next_data_b = O_DATA_B;
    next_ddr_clk = O_DDR_OUTPUT_CLOCK;
    next_cmos_clk = O_CMOS_OUTPUT_CLOCK;
    if (off) begin
      next_data_a = '0;
      next_data_b = '0;
      next_ddr_clk = 1'b0;
      next_cmos_clk = 1'b0;
    end else if (style_cmos) begin
      next_ddr_clk = 1'b0;
      if (sclk_rise) begin
        next_data_a = src_a;
        next_data_b = word_b;
        next_cmos_clk = 1'b0;
      end else if (sclk_fall) begin
        next_cmos_clk = 1'b1;
      end
    end else begin
      next_cmos_clk = 1'b0;
      // Pin k carries bit k: odd bits with clock high, even bits with clock low, zero otherwise
      for (int k = 0; k < WIDTH; k++) begin
        if (sclk_fall) begin
          next_data_a[k] = (k % 2 == 0) ? src_a[k] : 1'b0;
          next_data_b[k] = (k % 2 == 0) ? word_b[k] : 1'b0;
        end else if (sclk_rise) begin
          next_data_a[k] = (k % 2 == 1) ? src_a[k] : 1'b0;
          next_data_b[k] = (k % 2 == 1) ? word_b[k] : 1'b0;
        end
      end
      if (sclk_rise) begin
        next_ddr_clk = 1'b1;
      end else if (sclk_fall) begin
        next_ddr_clk = 1'b0;
      end
    end
    next_oe_a = {WIDTH{oe_a}};
    next_oe_b = {WIDTH{oe_b}};
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      word_a <= '0;
      word_b <= '0;
      mux_sel <= 1'b0;
      O_DATA_A <= '0;
      O_DATA_B <= '0;
      O_DATA_A_OE <= '0;
      O_DATA_B_OE <= '0;
      O_DDR_OUTPUT_CLOCK <= 1'b0;
      O_CMOS_OUTPUT_CLOCK <= 1'b0;
      O_CONV_A_ON <= 1'b0;
      O_CONV_B_ON <= 1'b0;
      O_REF_ON <= 1'b0;
      O_LOW_POWER <= 1'b0;
      O_DATA_VALID <= 1'b0;
      O_RDATA <= 8'h00;
    end else begin
      word_a <= next_word_a;
      word_b <= next_word_b;
      mux_sel <= next_mux_sel;
      O_DATA_A <= next_data_a;
      O_DATA_B <= next_data_b;
      O_DATA_A_OE <= next_oe_a;
      O_DATA_B_OE <= next_oe_b;
      O_DDR_OUTPUT_CLOCK <= next_ddr_clk;
      O_CMOS_OUTPUT_CLOCK <= next_cmos_clk;
      O_CONV_A_ON <= !off && !stby_a;
      O_CONV_B_ON <= !off && !stby_b;
      O_REF_ON <= !off;
      O_LOW_POWER <= off;
      O_DATA_VALID <= (state == ST_RUN);
      O_RDATA <= next_rdata;
    end
  end
endmodule
`default_nettype wire

// file: dv/adc_fmt_checker.sv
// Port assertions for the power-state and output formatter.
// Assumes one clock domain; bound to every instance of the top module.
`timescale 1ns/1ps
`default_nettype none
module adc_fmt_checker #(
  parameter int WIDTH = 11,
  parameter int GLOBAL_WAKE = 8
) (
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic I_RD,
  input wire logic [7:0] O_RDATA,
  input wire logic [WIDTH-1:0] O_DATA_A,
  input wire logic [WIDTH-1:0] O_DATA_A_OE,
  input wire logic [WIDTH-1:0] O_DATA_B_OE,
  input wire logic O_DDR_OUTPUT_CLOCK,
  input wire logic O_CMOS_OUTPUT_CLOCK,
  input wire logic O_CONV_A_ON,
  input wire logic O_CONV_B_ON,
  input wire logic O_REF_ON,
  input wire logic O_LOW_POWER,
  input wire logic O_DATA_VALID
);
  logic seen_run;
  logic next_seen_run;
  // Skips the first power-up after each reset
  always_comb begin
    next_seen_run = seen_run | O_DATA_VALID;
  end
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      seen_run <= 1'b0;
    end else begin
      seen_run <= next_seen_run;
    end
  end
  default clocking dc @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);
  a_read_idle: assert property (!$past(I_RD) |-> O_RDATA == 8'h00)
    else $error("read data outside answer");
  a_down_floats: assert property (!O_REF_ON && !$past(O_REF_ON) |->
    O_DATA_A_OE == '0 && O_DATA_B_OE == '0 && O_DATA_A == '0) else $error("not floated");
  a_down_conv_off: assert property (!O_REF_ON && !$past(O_REF_ON) |->
    !O_CONV_A_ON && !O_CONV_B_ON) else $error("converter on in power down");
  a_slow_floats: assert property (O_LOW_POWER && $past(O_LOW_POWER) |->
    O_DATA_A_OE == '0 && O_DATA_B_OE == '0) else $error("driving in low power");
  a_one_style: assert property (!(O_DDR_OUTPUT_CLOCK && O_CMOS_OUTPUT_CLOCK))
    else $error("both output clocks");
  a_ddr_odd_phase: assert property ($rose(O_DDR_OUTPUT_CLOCK) |->
    (O_DATA_A & 11'h555) == 11'h000) else $error("even bit in high phase");
  a_cmos_steady: assert property ($rose(O_CMOS_OUTPUT_CLOCK) |-> $stable(O_DATA_A))
    else $error("data moved at clock rise");
  a_wake_holds: assert property (seen_run && $rose(O_REF_ON) |-> !O_DATA_VALID [*4])
    else $error("valid too early");
  a_standby_ref: assert property (O_CONV_A_ON != O_CONV_B_ON |-> O_REF_ON)
    else $error("reference off in standby");
endmodule
bind adc_power_and_output_formatter adc_fmt_checker #(.WIDTH(WIDTH), .GLOBAL_WAKE(GLOBAL_WAKE))
  i_chk (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_RD(I_RD), .O_RDATA(O_RDATA),
  .O_DATA_A(O_DATA_A), .O_DATA_A_OE(O_DATA_A_OE), .O_DATA_B_OE(O_DATA_B_OE),
  .O_DDR_OUTPUT_CLOCK(O_DDR_OUTPUT_CLOCK), .O_CMOS_OUTPUT_CLOCK(O_CMOS_OUTPUT_CLOCK),
  .O_CONV_A_ON(O_CONV_A_ON), .O_CONV_B_ON(O_CONV_B_ON), .O_REF_ON(O_REF_ON),
  .O_LOW_POWER(O_LOW_POWER), .O_DATA_VALID(O_DATA_VALID));
`default_nettype wire

// file: dv/capture_receiver.sv
// Capture receiver model rebuilding one word per sample on each bus.
// Assumes resolved pads, polled on the system clock.
`timescale 1ns/1ps
`default_nettype none
module capture_receiver (
  input wire logic i_clk,
  input wire logic i_ddr_clk,
  input wire logic i_cmos_clk,
  input wire logic [10:0] i_pad_a,
  input wire logic [10:0] i_pad_b,
  output logic [10:0] o_word_a,
  output logic [10:0] o_word_b
);
  logic ddr_last = 1'b0;
  logic cmos_last = 1'b0;
  logic [10:0] even_a, even_b;
  // Even half of a word comes first, completed by the next rise
  always @(posedge i_clk) begin
    ddr_last <= i_ddr_clk;
    cmos_last <= i_cmos_clk;
    if (!i_ddr_clk && ddr_last) begin
      even_a <= i_pad_a & 11'h555;
      even_b <= i_pad_b & 11'h555;
    end
    if (i_ddr_clk && !ddr_last) begin
      o_word_a <= even_a | (i_pad_a & 11'h2AA);
      o_word_b <= even_b | (i_pad_b & 11'h2AA);
    end
    // Slow sampling rate, so the output clock is good enough
    if (i_cmos_clk && !cmos_last) begin
      o_word_a <= i_pad_a;
      o_word_b <= i_pad_b;
    end
  end
endmodule
`default_nettype wire

// file: dv/tb.sv
// Self-checking bench for the formatter with receiver model.
// Assumes package, design, checker and receiver compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) \
  begin \
    n_checks++; \
    if ((gt) !== (ex)) begin \
      miscompares++; \
      $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, gt); \
    end \
  end
module tb;
  logic clk, smp;
  logic rst_n = 1'b0, wr = 1'b0, rd = 1'b0, fpin = 1'b0, smp_run = 1'b1;
  logic p1 = 1'b0, p2 = 1'b0, p3 = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [10:0] raw_a = 11'h123, raw_b = 11'h5A6;
  logic [1:0] ovp = 2'b00, ovn = 2'b00;
  logic [10:0] d_a, d_b, oe_a, oe_b, pad_a, pad_b, word_a, word_b;
  logic ddr_clk, cmos_clk, ca, cb, ref_on, lowp, dvalid;
  int miscompares = 0, n_checks = 0, cycles = 0;
  function automatic logic [10:0] pads(input logic [10:0] d, input logic [10:0] oe);
    // Released pins read as the inverse of the current data output register bit
    for (int k = 0; k < 11; k++) begin
      pads[k] = oe[k] ? d[k] : ~d[k];
    end
  endfunction
  assign pad_a = pads(d_a, oe_a);
  assign pad_b = pads(d_b, oe_b);
  adc_power_and_output_formatter #(.GLOBAL_WAKE(8)) i_dut (
    .I_CLK(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
    .O_RDATA(rdata), .I_POWER_PIN_FIRST(p1), .I_POWER_PIN_SECOND(p2),
    .I_POWER_PIN_THIRD(p3), .I_FORMAT_SELECT_PIN(fpin), .I_SAMPLE_CLK(smp),
    .I_RAW_A(raw_a), .I_RAW_B(raw_b), .I_OVER_POS(ovp), .I_OVER_NEG(ovn),
    .O_DATA_A(d_a), .O_DATA_B(d_b), .O_DATA_A_OE(oe_a), .O_DATA_B_OE(oe_b),
    .O_DDR_OUTPUT_CLOCK(ddr_clk), .O_CMOS_OUTPUT_CLOCK(cmos_clk), .O_CONV_A_ON(ca),
    .O_CONV_B_ON(cb), .O_REF_ON(ref_on), .O_LOW_POWER(lowp), .O_DATA_VALID(dvalid));
  capture_receiver i_rx (.i_clk(clk), .i_ddr_clk(ddr_clk), .i_cmos_clk(cmos_clk),
    .i_pad_a(pad_a), .i_pad_b(pad_b), .o_word_a(word_a), .o_word_b(word_b));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Sampling clock, phase unrelated to the system clock
  initial begin
    smp = 1'b0;
    #37;
    forever #200 smp = smp_run & ~smp;
  end
  task automatic complete_run();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      miscompares++;
      complete_run();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Expected bits: ref, conv A, conv B, bus A driven, bus B driven
  task automatic chk_pwr(input logic [4:0] e, input logic [4:0] m);
    logic [4:0] g;
    g = {ref_on, ca, cb, e[1] ? &oe_a : |oe_a, e[0] ? &oe_b : |oe_b};
    `CHK("power outputs", e & m, g & m)
  endtask
  task automatic t_regs();
    logic [7:0] v;
    rd_reg(8'h00, v);
    `CHK("power reg", 8'h00, v)
    rd_reg(8'h02, v);
    `CHK("status", 8'h10, v)
    wr_reg(8'h01, 8'h03);
    rd_reg(8'h01, v);
    `CHK("output reg", 8'h03, v)
    wr_reg(8'h33, 8'hFF);
    rd_reg(8'h33, v);
    `CHK("unmapped", 8'h00, v)
    $display("regs done");
  endtask
  task automatic t_format();
    logic [10:0] ea, eb;
    for (int m = 0; m < 4; m++) begin
      for (int ov = 0; ov < 3; ov++) begin
        wr_reg(8'h01, 8'(m));
        ovp <= (ov == 1) ? 2'b11 : 2'b00;
        ovn <= (ov == 2) ? 2'b11 : 2'b00;
        cyc(40);
        ea = (ov == 1) ? (m[1] ? 11'h3FF : 11'h7FF) : (m[1] ? 11'h400 : 11'h000);
        eb = ea;
        if (ov == 0) begin
          ea = raw_a ^ {m[1], 10'h000};
          eb = raw_b ^ {m[1], 10'h000};
        end
        `CHK("words", {ea, eb}, {word_a, word_b})
      end
    end
    ovp <= 2'b00;
    ovn <= 2'b00;
    $display("format done");
  endtask
  task automatic t_mux();
    logic [10:0] w;
    wr_reg(8'h01, 8'h00);
    wr_reg(8'h00, 8'h0F);
    cyc(40);
    w = word_a;
    cyc(8);
    `CHK("mux words", {raw_a ^ raw_b, 1'b1}, {w ^ word_a, w == raw_a || w == raw_b})
    wr_reg(8'h00, 8'h00);
    cyc(4);
    $display("mux done");
  endtask
  task automatic t_power();
    logic [3:0] codes [8] = '{4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF, 4'h5};
    logic [4:0] exps [8] = '{5'h1E, 5'h1D, 5'h1C, 5'h00, 5'h18, 5'h14, 5'h1E, 5'h1F};
    logic [4:0] msks [8] = '{5'h1F, 5'h1F, 5'h1F, 5'h1F, 5'h1C, 5'h1C, 5'h1F, 5'h1F};
    for (int i = 0; i < 8; i++) begin
      wr_reg(8'h00, {4'h0, codes[i]});
      cyc(30);
      chk_pwr(exps[i], msks[i]);
      wr_reg(8'h00, 8'h00);
      cyc(19);
      `CHK("valid in wake", !(codes[i] inside {4'hD, 4'hE}), dvalid)
      cyc(21);
      `CHK("valid after wake", 1'b1, dvalid)
    end
    $display("power done");
  endtask
  task automatic t_pins();
    logic [2:0] pins [5] = '{3'b001, 3'b101, 3'b011, 3'b111, 3'b000};
    logic [4:0] exps [5] = '{5'h00, 5'h18, 5'h14, 5'h1E, 5'h1F};
    logic [4:0] msks [5] = '{5'h1F, 5'h1C, 5'h1C, 5'h1F, 5'h1F};
    wr_reg(8'h00, 8'h0C);
    wr_reg(8'h01, 8'h04);
    for (int i = 0; i < 5; i++) begin
      {p3, p2, p1} <= pins[i];
      cyc(40);
      chk_pwr(exps[i], msks[i]);
    end
    fpin <= 1'b1;
    cyc(40);
    `CHK("pin format", {1'b0, raw_a ^ 11'h400}, {ddr_clk, word_a})
    fpin <= 1'b0;
    wr_reg(8'h01, 8'h00);
    wr_reg(8'h00, 8'h00);
    cyc(40);
    $display("pins done");
  endtask
  task automatic t_slow();
    int n;
    smp_run <= 1'b0;
    cyc(40);
    `CHK("slow state", {1'b1, 11'h000}, {lowp, oe_a | oe_b})
    smp_run <= 1'b1;
    n = 0;
    while (dvalid !== 1'b1 && n < 200) begin
      cyc(1);
      n++;
    end
    `CHK("slow wake", 2'b01, {lowp, dvalid})
    $display("slow done");
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    cyc(2);
    t_regs();
    t_format();
    t_mux();
    t_power();
    t_pins();
    t_slow();
    complete_run();
  end
endmodule
`default_nettype wire
